// file: common/rfp_pkg.sv
// Purpose: shared constants and types for the frame row packer
// Assumes: one clock, synchronous active-high reset, 32-bit register port
// Notes:   register offsets, control bit positions, header codes and the column reset value live here
package rfp_pkg;

	// ==========================================================
	// matrix geometry
	localparam logic [7:0]  ROW_LAST    = 8'hBA;   // last of 187 payload rows
	localparam logic [10:0] HDR_BYTES   = 11'h002; // row header length
	localparam logic [10:0] CRC_BYTES   = 11'h002; // checksum columns added downstream
	localparam logic [10:0] NCOL_RST    = 11'h040; // columns per row after reset

	// ==========================================================
	// row header fields and codes
	localparam logic [10:0] PTR_NONE    = 11'h7FF;
	localparam logic [7:0]  STUFF_ONE   = 8'hFF;
	localparam logic [15:0] STUFF_TWO   = 16'hFEFF;
	localparam logic [7:0]  STUFF_FILL  = 8'hFF;
	localparam logic [2:0]  KIND_IPV4   = 3'h0;
	localparam logic [2:0]  KIND_FRAMED = 3'h1;
	localparam logic [1:0]  FHDR_LAST   = 2'h3;    // framed header is four bytes

	// ==========================================================
	// register map
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_NCOL0   = 8'h04;
	localparam logic [7:0]  REG_NCOL1   = 8'h08;
	localparam logic [7:0]  REG_FLUSH   = 8'h0C;
	localparam logic [7:0]  REG_STAT0   = 8'h10;
	localparam logic [7:0]  REG_STAT1   = 8'h14;
	localparam int          CTRL_STRICT = 0;
	localparam int          CTRL_DUAL   = 1;
	localparam int          CTRL_MIX    = 2;

	// ==========================================================
	// types
	typedef logic [2:0] rfp_kind_t;

	typedef enum logic [5:0] {
		S_IDLE  = 6'h01,
		S_FHDR  = 6'h02,
		S_HDR0  = 6'h04,
		S_HDR1  = 6'h08,
		S_STUFF = 6'h10,
		S_BODY  = 6'h20
	} rfp_state_t;

endpackage

// file: hw/rfp_row_packer.sv
// Purpose: pack protocol packets into the header-led rows of a frame payload
// Assumes: source and encoder share ref_clk_i; one packet byte per accepted cycle
// Notes:   rows are built in a per-ensemble buffer and streamed out once closed
//
// Contract
// - payload is 187 rows of N columns, N set per ensemble
// - encoder later appends a 16-bit checksum in two columns and parity rows
// - each row starts with two header bytes: kind, error flag, pointer
// - kind field names the type of the first packet bytes in the row
// - IPv4 packets go into rows without added encapsulation
// - framed packets start with a 32-bit length and protocol header
// - framed protocol codes are the Ethernet payload type codes
// - prefer one type per row; mixing only when enabled, never with framed
// - error flag set when the row holds known bad bytes, else clear
// - pointer gives offset of first packet starting in the row
// - pointer is 0x7FF when no packet starts in the row
// - packets packed back to back; overflow continues in next row
// - continuation may fall in the next frame; state survives frames
// - classify packets by type and steer types into separate rows
// - rows of any type may interleave; arrival order is kept
// - strict mode closes the row whenever the packet type changes
// - when input runs short, pad rows with stuffing to finish a frame
// - stuffing sits at the start of a row's payload, never the end
// - stuffing flag is 1 in rows with stuffing, else 0
// - stuffing length: 0xFF one byte, 0xFEFF two, else two-byte count
// - each ensemble has its own frame sequence and packing state
// - one or two ensembles per parade, each a separate stream
`timescale 1ns/1ns
`default_nettype none

module rfp_row_packer (
	// clock and reset
	input  wire logic               ref_clk_i,
	input  wire logic               reset_i,
	// register port
	input  wire logic [7:0]         reg_addr_i,
	input  wire logic [31:0]        reg_wdata_i,
	input  wire logic               reg_we_i,
	input  wire logic               reg_re_i,
	output logic      [31:0]        reg_rdata_o,
	// packet source
	input  wire logic               pkt_valid_i,
	input  wire logic [7:0]         pkt_data_i,
	input  wire logic               pkt_sop_i,
	input  wire rfp_pkg::rfp_kind_t pkt_kind_i,
	input  wire logic               pkt_ens_i,
	input  wire logic               pkt_err_i,
	input  wire logic [15:0]        pkt_len_i,
	input  wire logic [15:0]        pkt_proto_i,
	output logic                    pkt_ready_o,
	// row stream to the encoder
	output logic                    row_valid_o,
	output logic      [7:0]         row_data_o,
	output logic                    row_first_o,
	output logic                    row_last_o,
	output logic                    frame_last_o,
	output logic                    row_ens_o,
	input  wire logic               out_ready_i
);
	import rfp_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic [10:0] plen(input logic [10:0] ncol);
		plen = ncol - HDR_BYTES;
	endfunction

	// leading stuffing byte k of a run of n bytes
	function automatic logic [7:0] stuff_byte(input logic [10:0] n, input logic [10:0] k);
		if (n == 11'h001)
			stuff_byte = STUFF_ONE;
		else if (n == 11'h002)
			stuff_byte = (k == 11'h000) ? STUFF_TWO[15:8] : STUFF_TWO[7:0];
		else if (k == 11'h000)
			stuff_byte = {5'h00, n[10:8]};
		else if (k == 11'h001)
			stuff_byte = n[7:0];
		else
			stuff_byte = STUFF_FILL;
	endfunction

	// ==========================================================
	// state
	rfp_state_t  state_q, state_d;
	logic        em_q, em_d;
	logic [10:0] cnt_q, cnt_d;
	logic [10:0] fill_q [2];
	logic [10:0] fill_d [2];
	logic [10:0] ptr_q [2];
	logic [10:0] ptr_d [2];
	rfp_kind_t   kind_q [2];
	rfp_kind_t   kind_d [2];
	logic [1:0]  err_q, err_d;
	logic [7:0]  ridx_q [2];
	logic [7:0]  ridx_d [2];
	logic [1:0]  flush_q, flush_d, flush_set;
	logic        h_v_q, h_v_d, h_sop_q, h_sop_d, h_ens_q, h_ens_d, h_err_q, h_err_d;
	logic [7:0]  h_data_q, h_data_d;
	rfp_kind_t   h_kind_q, h_kind_d;
	logic [15:0] h_len_q, h_len_d, h_proto_q, h_proto_d;
	logic [1:0]  fh_cnt_q, fh_cnt_d;
	logic        fh_act_q, fh_act_d, hdr_done_q, hdr_done_d;
	logic        ready_q, ready_d;
	logic        ov_q, ov_d, ofirst_q, ofirst_d, olast_q, olast_d;
	logic        oflast_q, oflast_d, oens_q, oens_d;
	logic [7:0]  od_q, od_d;
	logic        strict_q, strict_d, dual_q, dual_d, mix_q, mix_d;
	logic [10:0] ncol_q [2];
	logic [10:0] ncol_d [2];
	logic [31:0] rdata_q, rdata_d;
	logic [7:0]  mem [0:4095];

	// combinational working signals
	logic        take, src_v, src_sop, src_err, e, conflict, step, row_end, frame_end;
	logic [7:0]  src_data;
	rfp_kind_t   src_kind;
	logic        wr_en, wr_e, wr_start, wr_err;
	logic [7:0]  wr_data;
	rfp_kind_t   wr_kind;
	logic [11:0] wr_addr;
	logic [10:0] stuff_n, row_ptr;
	logic [15:0] hdr_w;
	logic [31:0] fh_word;

	// ==========================================================
	// register port: config, flush requests, per-ensemble status
	always_comb begin
		strict_d  = strict_q;
		dual_d    = dual_q;
		mix_d     = mix_q;
		ncol_d    = ncol_q;
		flush_set = 2'h0;
		rdata_d   = 32'h0000_0000;
		if (reg_we_i) begin
			unique case (reg_addr_i)
				REG_CTRL: begin
					strict_d = reg_wdata_i[CTRL_STRICT];
					dual_d   = reg_wdata_i[CTRL_DUAL];
					mix_d    = reg_wdata_i[CTRL_MIX];
				end
				REG_NCOL0: ncol_d[0] = reg_wdata_i[10:0];
				REG_NCOL1: ncol_d[1] = reg_wdata_i[10:0];
				REG_FLUSH: flush_set = reg_wdata_i[1:0];
				default: ;
			endcase
		end
		if (reg_re_i) begin
			unique case (reg_addr_i)
				REG_CTRL:  rdata_d = {29'h0, mix_q, dual_q, strict_q};
				REG_NCOL0: rdata_d = {21'h0, ncol_q[0]};
				REG_NCOL1: rdata_d = {21'h0, ncol_q[1]};
				REG_FLUSH: rdata_d = {30'h0, flush_q};
				REG_STAT0: rdata_d = {5'h00, fill_q[0], 8'h00, ridx_q[0]};
				REG_STAT1: rdata_d = {5'h00, fill_q[1], 8'h00, ridx_q[1]};
				default:   rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// packing and emission
	always_comb begin
		state_d = state_q;  em_d = em_q;  cnt_d = cnt_q;
		fill_d = fill_q;  ptr_d = ptr_q;  kind_d = kind_q;  err_d = err_q;
		ridx_d = ridx_q;
		h_v_d = h_v_q;  h_sop_d = h_sop_q;  h_ens_d = h_ens_q;  h_err_d = h_err_q;
		h_data_d = h_data_q;  h_kind_d = h_kind_q;  h_len_d = h_len_q;  h_proto_d = h_proto_q;
		fh_cnt_d = fh_cnt_q;  fh_act_d = fh_act_q;  hdr_done_d = hdr_done_q;
		ofirst_d = ofirst_q;  olast_d = olast_q;  oflast_d = oflast_q;
		oens_d = oens_q;  od_d = od_q;
		ov_d = ov_q && !out_ready_i;
		step = !ov_q || out_ready_i;
		row_end = 1'b0;
		frame_end = 1'b0;
		wr_en = 1'b0;  wr_e = 1'b0;  wr_start = 1'b0;  wr_err = 1'b0;
		wr_data = 8'h00;  wr_kind = KIND_IPV4;
		// held byte has priority; a fresh one only arrives while nothing is held
		take     = pkt_valid_i && ready_q;
		src_v    = h_v_q || take;
		src_data = h_v_q ? h_data_q : pkt_data_i;
		src_sop  = h_v_q ? h_sop_q  : pkt_sop_i;
		src_kind = h_v_q ? h_kind_q : pkt_kind_i;
		src_err  = h_v_q ? h_err_q  : pkt_err_i;
		e        = dual_q && (h_v_q ? h_ens_q : pkt_ens_i);
		// a new packet of another type closes the row unless mixing is allowed
		conflict = src_sop && (fill_q[e] != 11'h000) && (src_kind != kind_q[e]) &&
			(strict_q || !mix_q || src_kind == KIND_FRAMED ||
			kind_q[e] == KIND_FRAMED);
		// header of the row being emitted; stuffing leads, so the pointer shifts
		stuff_n = plen(ncol_q[em_q]) - fill_q[em_q];
		row_ptr = (ptr_q[em_q] == PTR_NONE) ? PTR_NONE : ptr_q[em_q] + stuff_n;
		hdr_w   = {kind_q[em_q], err_q[em_q], stuff_n != 11'h000, row_ptr};
		fh_word = {h_len_q, h_proto_q};

		unique case (state_q)
			S_IDLE: begin
				if (src_v && (conflict ||
					(src_sop && src_kind == KIND_FRAMED && !hdr_done_q))) begin
					// park the byte; either close the row or insert the framed header
					h_v_d = 1'b1;  h_data_d = src_data;  h_sop_d = src_sop;
					h_kind_d = src_kind;  h_err_d = src_err;  h_ens_d = e;
					if (take) begin
						h_len_d   = pkt_len_i;
						h_proto_d = pkt_proto_i;
					end
					if (conflict) begin
						state_d = S_HDR0;
						em_d    = e;
						cnt_d   = 11'h000;
					end else begin
						state_d  = S_FHDR;
						fh_act_d = 1'b1;
						fh_cnt_d = 2'h0;
					end
				end else if (src_v) begin
					// plain bytes go straight into the row
					wr_en = 1'b1;  wr_e = e;  wr_data = src_data;
					wr_start = src_sop && !hdr_done_q;
					wr_err = src_err;  wr_kind = src_kind;
					h_v_d = 1'b0;
					hdr_done_d = 1'b0;
				end else if (flush_q != 2'h0) begin
					state_d = S_HDR0;
					em_d    = !flush_q[0];
					cnt_d   = 11'h000;
				end
			end
			S_FHDR: begin
				wr_en = 1'b1;  wr_e = h_ens_q;  wr_kind = KIND_FRAMED;
				wr_data  = fh_word[{~fh_cnt_q, 3'h0} +: 8];
				wr_start = (fh_cnt_q == 2'h0);
				fh_cnt_d = fh_cnt_q + 2'h1;
				if (fh_cnt_q == FHDR_LAST) begin
					fh_act_d   = 1'b0;
					hdr_done_d = 1'b1;
					state_d    = S_IDLE;
				end
			end
			S_HDR0: if (step) begin
				ov_d = 1'b1;  od_d = hdr_w[15:8];  ofirst_d = 1'b1;
				olast_d = 1'b0;  oflast_d = 1'b0;  oens_d = em_q;
				state_d = S_HDR1;
			end
			S_HDR1: if (step) begin
				ov_d = 1'b1;  od_d = hdr_w[7:0];  ofirst_d = 1'b0;
				cnt_d = 11'h000;
				state_d = (stuff_n != 11'h000) ? S_STUFF : S_BODY;
			end
			S_STUFF: if (step) begin
				ov_d = 1'b1;
				od_d = stuff_byte(stuff_n, cnt_q);
				cnt_d = cnt_q + 11'h001;
				if (cnt_q == stuff_n - 11'h001) begin
					cnt_d = 11'h000;
					if (fill_q[em_q] == 11'h000)
						row_end = 1'b1;
					else
						state_d = S_BODY;
				end
			end
			S_BODY: if (step) begin
				ov_d = 1'b1;
				od_d = mem[{em_q, cnt_q}];
				cnt_d = cnt_q + 11'h001;
				if (cnt_q == fill_q[em_q] - 11'h001)
					row_end = 1'b1;
			end
		endcase

		// byte into the ensemble's row buffer; a full row is sent at once
		if (wr_en) begin
			if (fill_q[wr_e] == 11'h000)
				kind_d[wr_e] = wr_kind;
			if (wr_start && ptr_q[wr_e] == PTR_NONE)
				ptr_d[wr_e] = fill_q[wr_e];
			err_d[wr_e]  = err_q[wr_e] | wr_err;
			fill_d[wr_e] = fill_q[wr_e] + 11'h001;
			if (fill_q[wr_e] + 11'h001 == plen(ncol_q[wr_e])) begin
				state_d = S_HDR0;
				em_d    = wr_e;
				cnt_d   = 11'h000;
			end
		end

		// row finished: clear row state, keep packet progress for the next row
		if (row_end) begin
			frame_end    = (ridx_q[em_q] == ROW_LAST);
			olast_d      = 1'b1;
			oflast_d     = frame_end;
			fill_d[em_q] = 11'h000;
			ptr_d[em_q]  = PTR_NONE;
			err_d[em_q]  = 1'b0;
			ridx_d[em_q] = frame_end ? 8'h00 : ridx_q[em_q] + 8'h01;
			if (flush_q[em_q] && !frame_end)
				state_d = S_HDR0;
			else if (h_v_q && fh_act_q)
				state_d = S_FHDR;
			else
				state_d = S_IDLE;
		end

		// a flush request in the cycle its frame completes is kept
		flush_d = flush_q;
		if (frame_end)
			flush_d[em_q] = 1'b0;
		flush_d = flush_d | flush_set;

		ready_d = (state_d == S_IDLE) && !h_v_d && (flush_d == 2'h0);
		wr_addr = {wr_e, fill_q[wr_e]};
	end

	// ==========================================================
	// registers
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			state_q <= S_IDLE;  em_q <= 1'b0;  cnt_q <= 11'h000;
			fill_q <= '{default: 11'h000};  ptr_q <= '{default: PTR_NONE};
			kind_q <= '{default: KIND_IPV4};  err_q <= 2'h0;
			ridx_q <= '{default: 8'h00};  flush_q <= 2'h0;
			h_v_q <= 1'b0;  h_sop_q <= 1'b0;  h_ens_q <= 1'b0;  h_err_q <= 1'b0;
			h_data_q <= 8'h00;  h_kind_q <= KIND_IPV4;
			h_len_q <= 16'h0000;  h_proto_q <= 16'h0000;
			fh_cnt_q <= 2'h0;  fh_act_q <= 1'b0;  hdr_done_q <= 1'b0;
			ready_q <= 1'b0;  ov_q <= 1'b0;  od_q <= 8'h00;
			ofirst_q <= 1'b0;  olast_q <= 1'b0;  oflast_q <= 1'b0;  oens_q <= 1'b0;
			strict_q <= 1'b0;  dual_q <= 1'b0;  mix_q <= 1'b0;
			ncol_q <= '{default: NCOL_RST};  rdata_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;  em_q <= em_d;  cnt_q <= cnt_d;
			fill_q <= fill_d;  ptr_q <= ptr_d;  kind_q <= kind_d;  err_q <= err_d;
			ridx_q <= ridx_d;  flush_q <= flush_d;
			h_v_q <= h_v_d;  h_sop_q <= h_sop_d;  h_ens_q <= h_ens_d;  h_err_q <= h_err_d;
			h_data_q <= h_data_d;  h_kind_q <= h_kind_d;
			h_len_q <= h_len_d;  h_proto_q <= h_proto_d;
			fh_cnt_q <= fh_cnt_d;  fh_act_q <= fh_act_d;  hdr_done_q <= hdr_done_d;
			ready_q <= ready_d;  ov_q <= ov_d;  od_q <= od_d;
			ofirst_q <= ofirst_d;  olast_q <= olast_d;  oflast_q <= oflast_d;
			oens_q <= oens_d;
			strict_q <= strict_d;  dual_q <= dual_d;  mix_q <= mix_d;
			ncol_q <= ncol_d;  rdata_q <= rdata_d;
		end
	end

	// row buffer: no reset needed, bytes are read only below the fill count
	always_ff @(posedge ref_clk_i) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	assign reg_rdata_o  = rdata_q;
	assign pkt_ready_o  = ready_q;
	assign row_valid_o  = ov_q;
	assign row_data_o   = od_q;
	assign row_first_o  = ofirst_q;
	assign row_last_o   = olast_q;
	assign frame_last_o = oflast_q;
	assign row_ens_o    = oens_q;

	// ==========================================================
	// assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	// stuffing flag is bit 3 of the high header byte, sent from S_HDR0
	a_stuff_flag: assert property ((state_q == S_HDR0) && step |=>
		row_data_o[3] == $past(stuff_n != 11'h000))
		else $error("stuffing flag does not match stuffing length");

	a_ptr_none: assert property ((state_q == S_HDR0) && step && ptr_q[em_q] == PTR_NONE
		##1 (state_q == S_HDR1) && step |=> row_data_o == 8'hFF)
		else $error("row without packet start lacks all-ones pointer");

	// emitted low pointer byte, worked out from width and fill, not from hdr_w
	a_ptr_offset: assert property ((state_q == S_HDR1) && step && ptr_q[em_q] != PTR_NONE |=>
		row_data_o == $past(8'(ptr_q[em_q] + ncol_q[em_q] - HDR_BYTES - fill_q[em_q])))
		else $error("pointer not shifted by leading stuffing");

	a_stuff_lead: assert property ($rose(state_q == S_BODY) |->
		$past(state_q) == S_STUFF || $past(state_q) == S_HDR1)
		else $error("packet bytes emitted before stuffing");

	a_stuff_one: assert property ((state_q == S_STUFF) && step && stuff_n == 11'h001 |=>
		row_data_o == STUFF_ONE && row_valid_o)
		else $error("single stuffing byte wrongly coded");

	a_row_full: assert property ((state_q == S_IDLE) && wr_en &&
		fill_q[wr_e] + 11'h001 == plen(ncol_q[wr_e]) |=> state_q == S_HDR0)
		else $error("full row not closed");

	a_type_close: assert property ((state_q == S_IDLE) && src_v && conflict |=>
		state_q == S_HDR0 && h_v_q && !pkt_ready_o)
		else $error("type change did not close the row");

	a_framed_hdr: assert property ($rose(fh_act_q) |-> (state_q == S_FHDR) &&
		wr_data == h_len_q[15:8])
		else $error("framed header does not start with length");

	a_row_range: assert property (ridx_q[0] <= ROW_LAST && ridx_q[1] <= ROW_LAST)
		else $error("row index beyond frame");

	a_out_hold: assert property (row_valid_o && !out_ready_i |=>
		row_valid_o && $stable(row_data_o) && $stable(row_last_o))
		else $error("row byte changed while stalled");

endmodule // rfp_row_packer

`default_nettype wire

// file: test/rfp_enc_model.sv
// Purpose: encoder side model that consumes the row stream
// Assumes: one byte per accepted edge; slow mode takes one byte in four
// Notes:   flags any row whose length differs from its ensemble's width
`timescale 1ns/1ns
`default_nettype none

module rfp_enc_model (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// pacing and row widths
	input  wire logic        slow_i,
	input  wire logic [10:0] ncol0_i,
	input  wire logic [10:0] ncol1_i,
	// row stream
	input  wire logic        row_valid_i,
	input  wire logic        row_last_i,
	input  wire logic        row_ens_i,
	output logic             out_ready_o,
	output logic             len_err_o
);
	logic [10:0] cnt_q;
	logic [1:0]  pace_q;

	// ==========================================================
	// ready pacing and row length count
	// ready only moves after an edge, so the packer must hold its byte
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cnt_q       <= 11'h000;
			pace_q      <= 2'h0;
			out_ready_o <= 1'b0;
			len_err_o   <= 1'b0;
		end else begin
			pace_q      <= pace_q + 2'h1;
			out_ready_o <= !slow_i || pace_q == 2'h1;
			len_err_o   <= 1'b0;
			if (row_valid_i && out_ready_o) begin
				cnt_q <= row_last_i ? 11'h000 : cnt_q + 11'h001;
				// row of N bytes; two checksum bytes would follow here
				if (row_last_i)
					len_err_o <= cnt_q + 11'h001 != (row_ens_i ? ncol1_i : ncol0_i);
			end
		end
	end
endmodule // rfp_enc_model

`default_nettype wire

// file: test/rfp_row_packer_tb.sv
// Purpose: self-checking bench for the frame row packer
// Assumes: encoder model paces the row stream; xorshift packet data
// Notes:   drivers queue expected bytes, monitors compare them in order
`timescale 1ns/1ns
`default_nettype none

module rfp_row_packer_tb;
	import rfp_pkg::*;

	// ==========================================================
	// signals
	logic        ref_clk_i, reset_i, reg_we, reg_re, rd_pend, slow;
	logic [7:0]  reg_addr, pkt_data, row_data;
	logic [31:0] reg_wdata, reg_rdata, seed;
	logic        pkt_valid, pkt_sop, pkt_ens, pkt_err, pkt_ready;
	logic [15:0] pkt_len, pkt_proto;
	rfp_kind_t   pkt_kind;
	logic        row_valid, row_first, row_last, frame_last, row_ens;
	logic        out_ready, len_err;
	logic [11:0] exp_q[$];
	logic [7:0]  src_q[$], drv_q[$];
	logic [31:0] reg_q[$];
	logic [10:0] ncol[2];
	int          ridx[2];
	int          failures, n_checks, cyc;

	rfp_row_packer i_dut (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_we_i(reg_we), .reg_re_i(reg_re),
		.reg_rdata_o(reg_rdata), .pkt_valid_i(pkt_valid), .pkt_data_i(pkt_data),
		.pkt_sop_i(pkt_sop), .pkt_kind_i(pkt_kind), .pkt_ens_i(pkt_ens),
		.pkt_err_i(pkt_err), .pkt_len_i(pkt_len), .pkt_proto_i(pkt_proto),
		.pkt_ready_o(pkt_ready), .row_valid_o(row_valid), .row_data_o(row_data),
		.row_first_o(row_first), .row_last_o(row_last), .frame_last_o(frame_last),
		.row_ens_o(row_ens), .out_ready_i(out_ready));

	rfp_enc_model i_enc (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .slow_i(slow),
		.ncol0_i(ncol[0]), .ncol1_i(ncol[1]), .row_valid_i(row_valid),
		.row_last_i(row_last), .row_ens_i(row_ens), .out_ready_o(out_ready),
		.len_err_o(len_err));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	function automatic logic [15:0] h(input rfp_kind_t k, input logic e, input logic s,
		input logic [10:0] p);
		return {k, e, s, p};
	endfunction

	// stuffing byte j of a run of s
	function automatic logic [7:0] stf(input int s, input int j);
		if (s == 2 && j == 0)
			return 8'hFE;
		if (s > 2 && j < 2)
			return j == 0 ? 8'(s >> 8) : 8'(s);
		return 8'hFF;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// register port and packet source drivers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_we    <= 1'b1;
		@(posedge ref_clk_i);
		reg_we    <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_re   <= 1'b1;
		reg_q.push_back(e);
		@(posedge ref_clk_i);
		reg_re   <= 1'b0;
	endtask

	// queue a packet: src_q as it lands in rows, drv_q as it is driven
	task automatic gen(input rfp_kind_t k, input int n);
		if (k == KIND_FRAMED) begin
			src_q.push_back(8'(n >> 8));
			src_q.push_back(8'(n));
			src_q.push_back(8'h08);
			src_q.push_back(8'h00);
		end
		for (int i = 0; i < n; i++) begin
			seed = xs(seed);
			src_q.push_back(seed[7:0]);
			drv_q.push_back(seed[7:0]);
		end
	endtask

	// one packet, byte held until taken; errb marks a bad byte
	task automatic send(input rfp_kind_t k, input logic e, input int n, input int errb);
		if (drv_q.size() == 0)
			gen(k, n);
		@(posedge ref_clk_i);
		pkt_kind  <= k;
		pkt_ens   <= e;
		pkt_len   <= 16'(n);
		pkt_proto <= 16'h0800;
		for (int i = 0; i < n; i++) begin
			pkt_data  <= drv_q.pop_front();
			pkt_sop   <= i == 0;
			pkt_err   <= i == errb;
			pkt_valid <= 1'b1;
			do @(posedge ref_clk_i); while (pkt_ready !== 1'b1);
		end
		pkt_valid <= 1'b0;
		pkt_err   <= 1'b0;
	endtask

	// expected row: header, s stuffing bytes, then queued packet bytes
	task automatic row(input logic e, input logic [15:0] hd, input int s);
		logic [7:0] b;
		int n;
		n = int'(ncol[e]);
		for (int i = 0; i < n; i++) begin
			if (i < 2)
				b = i == 0 ? hd[15:8] : hd[7:0];
			else if (i - 2 < s)
				b = stf(s, i - 2);
			else
				b = src_q.pop_front();
			exp_q.push_back({e, i == 0, i == n - 1 && ridx[e] == 186, i == n - 1, b});
		end
		ridx[e] = (ridx[e] + 1) % 187;
	endtask

	task automatic drain(input string t);
		int w;
		w = 0;
		while (exp_q.size() != 0 && w < 8000) begin
			@(posedge ref_clk_i);
			w++;
		end
		check(32'(exp_q.size()), 32'h0);
		$display("test %s done", t);
	endtask

	// ==========================================================
	// clock, timeout and monitors
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = !ref_clk_i;
	end

	// a hang ends in the closing report as a mismatch
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			$display("Error at %0t: cycles %h limit %h", $time, cyc, 20000);
			test_done();
		end
	end

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk_i) begin
		if (rd_pend === 1'b1)
			check(reg_rdata, reg_q.pop_front());
		rd_pend <= reg_re;
		if (len_err === 1'b1)
			check(32'h1, 32'h0);
		if (row_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0)
				check(32'(row_data), 32'hFFFFFFFF);
			else
				check(32'({row_ens, row_first, frame_last, row_last, row_data}),
					32'(exp_q.pop_front()));
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		{reg_we, reg_re, rd_pend, slow, pkt_valid, pkt_sop, pkt_ens, pkt_err} = 8'h00;
		{reg_addr, pkt_data, pkt_kind, pkt_len, pkt_proto} = 51'h0;
		reg_wdata = 32'h0;
		reset_i   = 1'b1;
		seed      = 32'h0B57;
		ncol      = '{11'h040, 11'h040};
		ridx      = '{0, 0};
		failures  = 0;
		n_checks  = 0;
		cyc       = 0;
		repeat (2) @(posedge ref_clk_i);
		reset_i <= 1'b0;
		rd(REG_CTRL, 32'h0);
		rd(REG_NCOL0, 32'h40);
		rd(REG_NCOL1, 32'h40);
		wr(REG_NCOL0, 32'h8);
		ncol[0] = 11'h008;
		wr(8'h18, 32'hFFFFFFFF);
		rd(REG_NCOL0, 32'h8);
		rd(8'h18, 32'h0);
		drain("registers");
		send(KIND_IPV4, 1'b0, 6, 2);
		row(1'b0, h(KIND_IPV4, 1'b1, 1'b0, 11'h000), 0);
		drain("error flag");
		slow <= 1'b1;
		for (int s = 1; s <= 3; s++) begin
			send(KIND_IPV4, 1'b0, 6 - s, -1);
			// the closed row leaves while the framed packet still waits
			row(1'b0, h(KIND_IPV4, 1'b0, 1'b1, 11'(s)), s);
			send(KIND_FRAMED, 1'b0, 2, -1);
			row(1'b0, h(KIND_FRAMED, 1'b0, 1'b0, 11'h000), 0);
		end
		drain("stuffing codes");
		slow <= 1'b0;
		wr(REG_CTRL, 32'h4);
		send(KIND_IPV4, 1'b0, 3, -1);
		send(3'h2, 1'b0, 3, -1);
		row(1'b0, h(KIND_IPV4, 1'b0, 1'b0, 11'h000), 0);
		wr(REG_CTRL, 32'h5);
		send(KIND_IPV4, 1'b0, 3, -1);
		row(1'b0, h(KIND_IPV4, 1'b0, 1'b1, 11'h003), 3);
		send(3'h2, 1'b0, 3, -1);
		send(3'h2, 1'b0, 3, -1);
		row(1'b0, h(3'h2, 1'b0, 1'b0, 11'h000), 0);
		drain("ordering modes");
		wr(REG_CTRL, 32'h0);
		// the first row goes out while the packet's tail still waits
		gen(KIND_IPV4, 9);
		row(1'b0, h(KIND_IPV4, 1'b0, 1'b0, 11'h000), 0);
		send(KIND_IPV4, 1'b0, 9, -1);
		wr(REG_FLUSH, 32'h1);
		row(1'b0, h(KIND_IPV4, 1'b0, 1'b1, PTR_NONE), 3);
		while (ridx[0] != 0)
			row(1'b0, h(KIND_IPV4, 1'b0, 1'b1, PTR_NONE), 6);
		drain("frame flush");
		rd(REG_FLUSH, 32'h0);
		wr(REG_NCOL1, 32'h6);
		ncol[1] = 11'h006;
		wr(REG_CTRL, 32'h2);
		send(KIND_IPV4, 1'b1, 4, 0);
		row(1'b1, h(KIND_IPV4, 1'b1, 1'b0, 11'h000), 0);
		send(KIND_IPV4, 1'b0, 6, -1);
		row(1'b0, h(KIND_IPV4, 1'b0, 1'b0, 11'h000), 0);
		drain("ensembles");
		rd(REG_CTRL, 32'h2);
		rd(REG_STAT0, 32'h1);
		rd(REG_STAT1, 32'h1);
		repeat (3) @(posedge ref_clk_i);
		test_done();
	end
endmodule // rfp_row_packer_tb

`default_nettype wire
